// ===== bad_map.svh
`ifndef BAD_MAP_SVH
`define BAD_MAP_SVH
// ****************************************************************
// Address map constants
// ****************************************************************
`define BAD_ROM_LO      16'hC000
`define BAD_VEC_LO      16'hFFD6
`define BAD_RAM_LO      16'h0080
`define BAD_RAM_HI      16'h027F
`define BAD_SFR_HI      16'h007F
`define BAD_BANK_ZERO   8'h00
`define BAD_PORT_LO     7'h02
`define BAD_PORT_HI     7'h14
`define BAD_AD_CTL      7'h1E
`define BAD_AD_SWEEP    7'h1F
`define BAD_AD_RES_LO   7'h20
`define BAD_AD_RES_HI   7'h2F
`define BAD_TMR_CNT_LO  7'h46
`define BAD_TMR_CNT_HI  7'h55
`define BAD_TMR_MODE_LO 7'h56
`define BAD_TMR_MODE_HI 7'h5D
`define BAD_PROC_MODE   7'h5E
`define BAD_WDT         7'h60
`define BAD_WDT_FSEL    7'h61
`define BAD_DPB_RST     16'h0000
`endif

// ===== bad_pkg.sv
package bad_pkg;
	typedef enum logic [2:0] {
		BAD_RGN_NONE,
		BAD_RGN_SFR,
		BAD_RGN_RAM,
		BAD_RGN_ROM,
		BAD_RGN_EXT
	} bad_region_e;

	typedef enum logic [3:0] {
		BAD_GRP_NONE,
		BAD_GRP_PORT_DATA,
		BAD_GRP_PORT_DIR,
		BAD_GRP_AD_CTL,
		BAD_GRP_AD_SWEEP,
		BAD_GRP_AD_RESULT,
		BAD_GRP_TMR_COUNT,
		BAD_GRP_TMR_MODE,
		BAD_GRP_PROC_MODE,
		BAD_GRP_WDT,
		BAD_GRP_WDT_FSEL,
		BAD_GRP_OTHER
	} bad_group_e;
endpackage : bad_pkg

// ===== bad_sfr_group.sv
`timescale 1ns/1ps
`include "bad_map.svh"
// ****************************************************************
// Peripheral register group decode, purely combinational
// ****************************************************************
module bad_sfr_group (
	input  wire logic [6:0]          offset,    // Offset within the register block
	output bad_pkg::bad_group_e      group,     // Selected register group
	output logic      [3:0]          index      // Port, channel or timer number
);
	logic [6:0] port_rel;

	// Ports come in pairs: two data bytes, then two direction bytes.
	assign port_rel = offset - `BAD_PORT_LO;

	always_comb begin
		group = bad_pkg::BAD_GRP_OTHER;
		index = 4'h0;
		if (offset >= `BAD_PORT_LO && offset <= `BAD_PORT_HI) begin
			group = port_rel[1] ? bad_pkg::BAD_GRP_PORT_DIR : bad_pkg::BAD_GRP_PORT_DATA;
			index = {port_rel[4:2], port_rel[0]};
		end else if (offset == `BAD_AD_CTL) begin
			group = bad_pkg::BAD_GRP_AD_CTL;
		end else if (offset == `BAD_AD_SWEEP) begin
			group = bad_pkg::BAD_GRP_AD_SWEEP;
		end else if (offset >= `BAD_AD_RES_LO && offset <= `BAD_AD_RES_HI) begin
			group = bad_pkg::BAD_GRP_AD_RESULT;
			index = {1'b0, offset[3:1]};
		end else if (offset >= `BAD_TMR_CNT_LO && offset <= `BAD_TMR_CNT_HI) begin
			group = bad_pkg::BAD_GRP_TMR_COUNT;
			index = 4'((offset - `BAD_TMR_CNT_LO) >> 1);
		end else if (offset >= `BAD_TMR_MODE_LO && offset <= `BAD_TMR_MODE_HI) begin
			group = bad_pkg::BAD_GRP_TMR_MODE;
			index = 4'(offset - `BAD_TMR_MODE_LO);
		end else if (offset == `BAD_PROC_MODE) begin
			group = bad_pkg::BAD_GRP_PROC_MODE;
		end else if (offset == `BAD_WDT) begin
			group = bad_pkg::BAD_GRP_WDT;
		end else if (offset == `BAD_WDT_FSEL) begin
			group = bad_pkg::BAD_GRP_WDT_FSEL;
		end
	end
endmodule : bad_sfr_group

// ===== bad_decoder.sv
`timescale 1ns/1ps
`include "bad_map.svh"
// What this block does
// - Accepts 24-bit addresses spanning the whole 16-Mbyte space.
// - Upper eight address bits form the bank number, 64-Kbyte banks.
// - ROM, RAM and peripheral registers match only in bank zero.
// - Bank zero offsets C000 to FFFF select the 16-Kbyte ROM.
// - Offsets FFD6 to FFFF are flagged as vector fetches from ROM.
// - Bank zero offsets 80 to 27F select the 512-byte RAM.
// - Stack pushes and pops decode by address like any other access; only RAM hits set the stack flag.
// - Bank zero offsets 0 to 7F select the peripheral register block.
// - Direct-page accesses add a programmable base, window anywhere in bank zero.
// - Port data and direction registers decoded in pairs from 02 to 14.
// - Converter control 1E, sweep 1F, eight result words from 20.
// - Timer counts from 46, timer mode bytes 56 to 5D.
// - Processor mode register selected at 5E.
// - Watchdog at 60, its frequency select flag at 61.
// - External bus is 16 bits only in expansion or processor mode with width select low, else 8.
module bad_decoder #(
	parameter int ADDR_W = 24                   // Address width
) (
	input  wire logic              clk,          // 40 MHz system clock
	input  wire logic              sys_rst,      // Asynchronous reset, active high
	input  wire logic              req_valid,    // Access request from bus interface unit
	input  wire logic [ADDR_W-1:0] req_addr,     // Full address of the access
	input  wire logic              req_dp,       // Access uses direct page addressing
	input  wire logic [7:0]        req_dp_off,   // Direct page offset byte
	input  wire logic              req_stack,    // Access is a stack push or pop
	input  wire logic              dpb_we,       // Load the direct page base
	input  wire logic [15:0]       dpb_wdata,    // New direct page base
	input  wire logic              bus_byte,     // Bus width select pin level
	input  wire logic              expand_mode,  // Memory expansion or processor mode
	output logic                   dec_valid_q,  // Decode result valid
	output logic [ADDR_W-1:0]      dec_addr_q,   // Effective address decoded
	output bad_pkg::bad_region_e   dec_region_q, // Selected region
	output bad_pkg::bad_group_e    dec_group_q,  // Peripheral register group
	output logic [3:0]             dec_index_q,  // Index within the group
	output logic                   dec_vector_q, // Vector area fetch
	output logic                   dec_stack_q,  // Stack access landed in RAM
	output logic                   dec_ext_q,    // Run an external cycle
	output logic                   bus_wide_q,   // External bus is 16 bits
	output logic [15:0]            direct_page_base_q // Direct page base
);
	// ****************************************************************
	// Effective address
	// ****************************************************************
	logic [ADDR_W-1:0]    eff_addr;
	logic [7:0]           bank;
	logic [15:0]          offs;
	bad_pkg::bad_region_e region_d;
	bad_pkg::bad_group_e  group;
	logic [3:0]           index;
	// Next values of the registered outputs.
	bad_pkg::bad_region_e dec_region_d;
	bad_pkg::bad_group_e  dec_group_d;
	logic [3:0]           dec_index_d;
	logic                 dec_vector_d;
	logic                 dec_stack_d;
	logic                 dec_ext_d;

	// The direct page wraps inside bank zero rather than spilling into bank one.
	always_comb begin
		eff_addr = req_addr;
		if (req_dp) begin
			eff_addr = ADDR_W'({8'h00, 16'(direct_page_base_q + {8'h00, req_dp_off})});
		end
	end

	assign bank = eff_addr[ADDR_W-1 -: 8];
	assign offs = eff_addr[15:0];

	// ****************************************************************
	// Region decode
	// ****************************************************************
	always_comb begin
		region_d = bad_pkg::BAD_RGN_EXT;
		if (bank == `BAD_BANK_ZERO) begin
			if (offs >= `BAD_ROM_LO) begin
				region_d = bad_pkg::BAD_RGN_ROM;
			end else if (offs >= `BAD_RAM_LO && offs <= `BAD_RAM_HI) begin
				region_d = bad_pkg::BAD_RGN_RAM;
			end else if (offs <= `BAD_SFR_HI) begin
				region_d = bad_pkg::BAD_RGN_SFR;
			end
		end
	end

	bad_sfr_group u_sfr (
		.offset (offs[6:0]),
		.group  (group),
		.index  (index)
	);

	// ****************************************************************
	// Direct page base
	// ****************************************************************
	// A load takes effect for direct-page requests taken from the next edge on.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			direct_page_base_q <= `BAD_DPB_RST;
		end else if (dpb_we) begin
			direct_page_base_q <= dpb_wdata;
		end
	end

	// ****************************************************************
	// Next values of the decode outputs
	// ****************************************************************
	// Everything but the address falls back to idle when no request is taken,
	// so a stale offset on the bus never selects a register or a memory.
	always_comb begin
		dec_region_d = bad_pkg::BAD_RGN_NONE;
		dec_group_d  = bad_pkg::BAD_GRP_NONE;
		dec_index_d  = 4'h0;
		dec_vector_d = 1'b0;
		dec_stack_d  = 1'b0;
		dec_ext_d    = 1'b0;
		if (req_valid) begin
			dec_region_d = region_d;
			if (region_d == bad_pkg::BAD_RGN_SFR) begin
				dec_group_d = group;
				dec_index_d = index;
			end
			if (region_d == bad_pkg::BAD_RGN_ROM && offs >= `BAD_VEC_LO) begin
				dec_vector_d = 1'b1;
			end
			if (region_d == bad_pkg::BAD_RGN_RAM && req_stack) begin
				dec_stack_d = 1'b1;
			end
			if (region_d == bad_pkg::BAD_RGN_EXT) begin
				dec_ext_d = 1'b1;
			end
		end
	end

	// ****************************************************************
	// Request echo
	// ****************************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_valid_q <= 1'b0;
		end else begin
			dec_valid_q <= req_valid;
		end
	end

	// The address is captured every cycle; consumers qualify it with the valid flag.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_addr_q <= '0;
		end else begin
			dec_addr_q <= eff_addr;
		end
	end

	// ****************************************************************
	// Region and access flags
	// ****************************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_region_q <= bad_pkg::BAD_RGN_NONE;
		end else begin
			dec_region_q <= dec_region_d;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_vector_q <= 1'b0;
		end else begin
			dec_vector_q <= dec_vector_d;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_stack_q <= 1'b0;
		end else begin
			dec_stack_q <= dec_stack_d;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_ext_q <= 1'b0;
		end else begin
			dec_ext_q <= dec_ext_d;
		end
	end

	// ****************************************************************
	// Peripheral register group
	// ****************************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_group_q <= bad_pkg::BAD_GRP_NONE;
		end else begin
			dec_group_q <= dec_group_d;
		end
	end

	// Both bytes of a two-byte register give the same index.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_index_q <= 4'h0;
		end else begin
			dec_index_q <= dec_index_d;
		end
	end

	// ****************************************************************
	// External bus width
	// ****************************************************************
	// Sampled every cycle so a pin change takes effect on the next access.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_wide_q <= 1'b0;
		end else begin
			bus_wide_q <= expand_mode && !bus_byte;
		end
	end
endmodule : bad_decoder

// ===== bad_decoder_asserts.sv
`timescale 1ns/1ps
// ****************************************************************
// Decode checks
// ****************************************************************
module bad_decoder_asserts #(
	parameter int ADDR_W = 24 // Address width
) (
	input wire logic                 clk,                // Clock
	input wire logic                 sys_rst,            // Reset
	input wire logic                 req_valid,          // Request
	input wire logic [ADDR_W-1:0]    req_addr,           // Address
	input wire logic                 req_dp,             // Direct page
	input wire logic [7:0]           req_dp_off,         // Page offset
	input wire logic                 expand_mode,        // Mode
	input wire logic                 bus_byte,           // Width pin
	input wire logic                 dec_valid_q,        // Valid
	input wire logic [ADDR_W-1:0]    dec_addr_q,         // Address out
	input wire bad_pkg::bad_region_e dec_region_q,       // Region
	input wire logic                 dec_vector_q,       // Vector
	input wire logic                 dec_stack_q,        // Stack
	input wire logic                 dec_ext_q,          // External
	input wire logic                 bus_wide_q,         // Wide bus
	input wire logic [15:0]          direct_page_base_q  // Page base
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic        a0  = req_valid && !req_dp && req_addr[ADDR_W-1:16] == 8'h00;
	wire logic [15:0] off = req_addr[15:0];
	valid_lat_a: assert property (req_valid |=> dec_valid_q) else $error("no valid");
	bank_ext_a: assert property (req_valid && !req_dp && !a0 |=> dec_ext_q)
		else $error("bank not external");
	rom_sel_a: assert property (a0 && off >= 16'hC000 |=> dec_region_q == bad_pkg::BAD_RGN_ROM)
		else $error("rom miss");
	vec_sel_a: assert property (a0 && off >= 16'hFFD6 |=> dec_vector_q) else $error("vector");
	ram_sel_a: assert property (a0 && off inside {[16'h0080:16'h027F]} |=>
		dec_region_q == bad_pkg::BAD_RGN_RAM) else $error("ram miss");
	stack_ram_a: assert property (dec_stack_q |-> dec_region_q == bad_pkg::BAD_RGN_RAM)
		else $error("stack outside ram");
	sfr_sel_a: assert property (a0 && off <= 16'h007F |=> dec_region_q == bad_pkg::BAD_RGN_SFR)
		else $error("sfr miss");
	dp_addr_a: assert property (req_valid && req_dp |=>
		dec_addr_q == {8'h00, $past(direct_page_base_q) + $past(req_dp_off)}) else $error("dp");
	bus_wide_a: assert property (expand_mode && !bus_byte |=> bus_wide_q) else $error("bus");
	gap_ext_a: assert property (a0 && off inside {[16'h0280:16'hBFFF]} |=> dec_ext_q)
		else $error("gap not external");
endmodule : bad_decoder_asserts
bind bad_decoder bad_decoder_asserts #(.ADDR_W(ADDR_W)) u_bad_decoder_asserts (
	.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_addr(req_addr), .req_dp(req_dp),
	.req_dp_off(req_dp_off), .expand_mode(expand_mode), .bus_byte(bus_byte),
	.dec_valid_q(dec_valid_q), .dec_addr_q(dec_addr_q), .dec_region_q(dec_region_q),
	.dec_vector_q(dec_vector_q), .dec_stack_q(dec_stack_q), .dec_ext_q(dec_ext_q),
	.bus_wide_q(bus_wide_q), .direct_page_base_q(direct_page_base_q));

// ===== bad_biu_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Bus interface unit issuing one access at a time
// ****************************************************************
module bad_biu_model (
	input  wire logic clk,        // Clock
	output logic      req_valid,  // Request
	output logic [23:0] req_addr, // Address
	output logic      req_dp,     // Direct page
	output logic [7:0] req_dp_off,// Page offset
	output logic      req_stack   // Stack access
);
	initial begin
		{req_valid, req_addr, req_dp, req_dp_off, req_stack} = '0;
	end
	task automatic issue(input logic [23:0] a, input logic dp, input logic [7:0] o, input logic s);
		@(negedge clk);
		{req_valid, req_addr, req_dp, req_dp_off, req_stack} = {1'b1, a, dp, o, s};
		@(negedge clk);
		req_valid = 1'b0;
		// Released lines flip so a stale value can never pass for a fresh one.
		req_addr = ~req_addr;
		req_dp_off = ~req_dp_off;
		req_dp = ~req_dp;
		req_stack = ~req_stack;
	endtask : issue
endmodule : bad_biu_model

// ===== tb_bank0_address_decoder.sv
`timescale 1ns/1ps
module tb_bank0_address_decoder;
	logic clk = 1'b0, sys_rst = 1'b1, dpb_we = 1'b0, bus_byte = 1'b0, expand_mode = 1'b0;
	logic [15:0] dpb_wdata = 16'h0000;
	logic req_valid, req_dp, req_stack, dec_valid_q, dec_vector_q, dec_stack_q, dec_ext_q, bus_wide_q;
	logic [23:0] req_addr, dec_addr_q;
	logic [7:0] req_dp_off;
	logic [3:0] dec_index_q;
	logic [15:0] direct_page_base_q;
	bad_pkg::bad_region_e dec_region_q;
	bad_pkg::bad_group_e dec_group_q;
	int fails = 0, checked = 0;
	always #12.5 clk = ~clk;
	bad_biu_model u_bad_biu_model (.clk(clk), .req_valid(req_valid), .req_addr(req_addr),
		.req_dp(req_dp), .req_dp_off(req_dp_off), .req_stack(req_stack));
	bad_decoder u_bad_decoder (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_addr(req_addr), .req_dp(req_dp), .req_dp_off(req_dp_off), .req_stack(req_stack),
		.dpb_we(dpb_we), .dpb_wdata(dpb_wdata), .bus_byte(bus_byte), .expand_mode(expand_mode),
		.dec_valid_q(dec_valid_q), .dec_addr_q(dec_addr_q), .dec_region_q(dec_region_q),
		.dec_group_q(dec_group_q), .dec_index_q(dec_index_q), .dec_vector_q(dec_vector_q),
		.dec_stack_q(dec_stack_q), .dec_ext_q(dec_ext_q), .bus_wide_q(bus_wide_q),
		.direct_page_base_q(direct_page_base_q));
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic t_regions;
		logic [23:0] t [13] = '{24'h000000, 24'h00007F, 24'h000080, 24'h00027F, 24'h000280,
			24'h00BFFF, 24'h00C000, 24'h00FFD5, 24'h00FFD6, 24'h00FFFF, 24'h010080, 24'hFF0000, 24'hFFFFFF};
		bad_pkg::bad_region_e r;
		foreach (t[i]) begin
			r = t[i][23:16] != 8'h00 ? bad_pkg::BAD_RGN_EXT : t[i] < 24'h80 ? bad_pkg::BAD_RGN_SFR :
				t[i] < 24'h280 ? bad_pkg::BAD_RGN_RAM : t[i] >= 24'hC000 ? bad_pkg::BAD_RGN_ROM : bad_pkg::BAD_RGN_EXT;
			u_bad_biu_model.issue(t[i], 1'b0, 8'h00, 1'b0);
			chk("valid", 24'h000001, 24'(dec_valid_q));
			chk("addr", t[i], dec_addr_q);
			chk("region", 24'(r), 24'(dec_region_q));
			chk("ext", 24'(r == bad_pkg::BAD_RGN_EXT), 24'(dec_ext_q));
			chk("vector", 24'(t[i] >= 24'h00FFD6 && t[i] <= 24'h00FFFF), 24'(dec_vector_q));
		end
	endtask : t_regions
	task automatic t_groups;
		// Packed as offset, group in enum order, index.
		logic [15:0] t [18] = '{16'h0210, 16'h0420, 16'h0612, 16'h1127, 16'h1218, 16'h1428,
			16'h1E30, 16'h1F40, 16'h2050, 16'h2F57, 16'h4660, 16'h5567, 16'h5670, 16'h5D77,
			16'h5E80, 16'h6090, 16'h61A0, 16'h00B0};
		foreach (t[i]) begin
			u_bad_biu_model.issue({16'h0000, t[i][15:8]}, 1'b0, 8'h00, 1'b0);
			chk("group", 24'(t[i][7:4]), 24'(dec_group_q));
			chk("index", 24'(t[i][3:0]), 24'(dec_index_q));
		end
	endtask : t_groups
	task automatic t_dp_stack;
		chk("base reset", 24'h000000, 24'(direct_page_base_q));
		@(negedge clk);
		dpb_we = 1'b1;
		dpb_wdata = 16'hFFC0;
		@(negedge clk);
		dpb_we = 1'b0;
		chk("base load", 24'h00FFC0, 24'(direct_page_base_q));
		u_bad_biu_model.issue(24'hFF8000, 1'b1, 8'h50, 1'b0);
		chk("dp addr", 24'h000010, dec_addr_q);
		chk("dp region", 24'(bad_pkg::BAD_RGN_SFR), 24'(dec_region_q));
		u_bad_biu_model.issue(24'h00027F, 1'b0, 8'h00, 1'b1);
		chk("stack ram", 24'h000001, 24'(dec_stack_q));
		u_bad_biu_model.issue(24'h00C000, 1'b0, 8'h00, 1'b1);
		chk("stack rom", 24'h000000, 24'(dec_stack_q));
		@(negedge clk);
		chk("idle region", 24'(bad_pkg::BAD_RGN_NONE), 24'(dec_region_q));
		chk("idle ext", 24'h000000, 24'(dec_ext_q));
	endtask : t_dp_stack
	task automatic t_bus;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			{expand_mode, bus_byte} = 2'(i);
			@(negedge clk);
			chk("bus wide", 24'(i == 2), 24'(bus_wide_q));
		end
	endtask : t_bus
	task automatic wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		t_regions();
		t_groups();
		t_dp_stack();
		t_bus();
		wrap_up();
	end
	initial begin
		#20000;
		fails++;
		wrap_up();
	end
endmodule : tb_bank0_address_decoder
